//--- rtl/irq_prio_pkg.sv
package irq_prio_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] DMA_PRIO_ADDR = 8'h00;
    localparam logic [7:0] RSVD_PRIO_ADDR = 8'h04;
    localparam logic [7:0] USB_FLASH_PRIO_ADDR = 8'h08;
    localparam logic [31:0] DMA_PRIO_RESET = 32'h0000_0000;
    localparam logic [31:0] USB_FLASH_PRIO_RESET = 32'h0000_0000;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int SUB_LSB = 0;
    localparam int PRIO_LSB = 2;
    localparam int BYTE_W = 8;
    localparam int DMA_CH_COUNT = 4;
    localparam int SRC_COUNT = 6;
    localparam logic [31:0] DMA_PRIO_WMASK = 32'h1f1f_1f1f;
    localparam logic [31:0] USB_FLASH_WMASK = 32'h0000_1f1f;
    localparam logic [2:0] PRIO_OFF = 3'h0;
    localparam logic [2:0] PRIO_MAX = 3'h7;
    localparam logic [1:0] SUB_MAX = 2'h3;

    // ****************************************
    // Vector numbers, arbitration order
    // ****************************************
    localparam logic [5:0] VEC_DMA0 = 6'h24;
    localparam logic [5:0] VEC_FLASH = 6'h2c;
    localparam logic [5:0] VEC_USB = 6'h2d;

    typedef struct packed {
        logic [2:0] prio;
        logic [1:0] sub;
    } src_cfg_type;

    typedef struct packed {
        logic valid;
        logic [5:0] vector;
        logic [2:0] level;
        logic [1:0] sub;
    } irq_pick_type;

endpackage

//--- rtl/irq_prio_arbiter.sv
module irq_prio_arbiter
    import irq_prio_pkg::*;
(
    input wire logic [SRC_COUNT-1:0] pending,
    input wire src_cfg_type [SRC_COUNT-1:0] cfg,
    output irq_pick_type pick
);

    // ****************************************
    // Source index to vector number
    // ****************************************
    function automatic logic [5:0] vecOf(input int idx);
        if (idx < DMA_CH_COUNT) begin
            vecOf = VEC_DMA0 + 6'(idx);
        end else if (idx == DMA_CH_COUNT) begin
            vecOf = VEC_USB;
        end else begin
            vecOf = VEC_FLASH;
        end
    endfunction

    // Natural order: lower vector wins a full tie
    function automatic int rankOf(input int idx);
        rankOf = (idx == DMA_CH_COUNT) ? SRC_COUNT : idx;
    endfunction

    always_comb begin
        irq_pick_type best;
        int bestRank;
        best = '0;
        bestRank = SRC_COUNT + 1;
        for (int i = 0; i < SRC_COUNT; i++) begin
            if (pending[i] && cfg[i].prio != PRIO_OFF) begin
                if (!best.valid || cfg[i].prio > best.level ||
                    (cfg[i].prio == best.level && cfg[i].sub > best.sub) ||
                    (cfg[i].prio == best.level && cfg[i].sub == best.sub && rankOf(i) < bestRank)) begin
                    best.valid = 1'b1;
                    best.vector = vecOf(i);
                    best.level = cfg[i].prio;
                    best.sub = cfg[i].sub;
                    bestRank = rankOf(i);
                end
            end
        end
        pick = best;
    end

endmodule

//--- rtl/irq_priority_config_bank.sv
// Chosen here: the placing of the registers and strobed register access.
module irq_priority_config_bank
    import irq_prio_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    input wire logic [DMA_CH_COUNT-1:0] dmaIrqPending,
    input wire logic usbIrqPending,
    input wire logic flashIrqPending,
    output logic reqValid,
    output logic [5:0] reqVector,
    output logic [2:0] reqLevel
);

    logic [31:0] dmaPrio_q;
    logic [31:0] usbFlashPrio_q;
    src_cfg_type [SRC_COUNT-1:0] cfg;
    irq_pick_type pick;

    // ****************************************
    // Field extraction
    // ****************************************
    function automatic src_cfg_type fieldAt(input logic [31:0] r, input int lane);
        logic [7:0] b;
        b = r[lane*BYTE_W +: BYTE_W];
        fieldAt.prio = b[PRIO_LSB +: 3];
        fieldAt.sub = b[SUB_LSB +: 2];
    endfunction

    // ****************************************
    // Register writes
    // ****************************************
    // Reset clears fields
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dmaPrio_q <= DMA_PRIO_RESET;
        end else if (regWrite && regAddr == DMA_PRIO_ADDR) begin
            dmaPrio_q <= regWdata & DMA_PRIO_WMASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            usbFlashPrio_q <= USB_FLASH_PRIO_RESET;
        end else if (regWrite && regAddr == USB_FLASH_PRIO_ADDR) begin
            usbFlashPrio_q <= regWdata & USB_FLASH_WMASK;
        end
    end

    // ****************************************
    // Register reads
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdata <= 32'h0000_0000;
        end else if (regRead) begin
            if (regAddr == DMA_PRIO_ADDR) begin
                regRdata <= dmaPrio_q;
            end else if (regAddr == USB_FLASH_PRIO_ADDR) begin
                regRdata <= usbFlashPrio_q;
            end else begin
                regRdata <= 32'h0000_0000;
            end
        end else begin
            regRdata <= 32'h0000_0000;
        end
    end

    // ****************************************
    // Source configuration
    // ****************************************
    // Lane per channel
    always_comb begin
        for (int c = 0; c < DMA_CH_COUNT; c++) begin
            cfg[c] = fieldAt(dmaPrio_q, c);
        end
        cfg[DMA_CH_COUNT] = fieldAt(usbFlashPrio_q, 1);
        cfg[DMA_CH_COUNT+1] = fieldAt(usbFlashPrio_q, 0);
    end

    irq_prio_arbiter arbiter (
        .pending({flashIrqPending, usbIrqPending, dmaIrqPending}),
        .cfg(cfg),
        .pick(pick)
    );

    // ****************************************
    // Request to core
    // ****************************************
    // Registered winner
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reqValid <= 1'b0;
            reqVector <= 6'h00;
            reqLevel <= 3'h0;
        end else begin
            reqValid <= pick.valid;
            reqVector <= pick.valid ? pick.vector : 6'h00;
            reqLevel <= pick.valid ? pick.level : 3'h0;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_reset_clear;
        @(posedge clk) $fell(rst) |-> dmaPrio_q == 32'h0 && usbFlashPrio_q == 32'h0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("fields not cleared");

    property p_ch2_field;
        @(posedge clk) disable iff (rst)
            regWrite && regAddr == DMA_PRIO_ADDR |=> cfg[2].prio == $past(regWdata[20:18]);
    endproperty
    a_ch2_field: assert property (p_ch2_field) else $error("ch2 priority misplaced");

    property p_ch1_field;
        @(posedge clk) disable iff (rst)
            regWrite && regAddr == DMA_PRIO_ADDR |=>
            cfg[1].prio == $past(regWdata[12:10]) && cfg[1].sub == $past(regWdata[9:8]);
    endproperty
    a_ch1_field: assert property (p_ch1_field) else $error("ch1 fields misplaced");

    property p_ch0_field;
        @(posedge clk) disable iff (rst)
            regWrite && regAddr == DMA_PRIO_ADDR |=>
            cfg[0].prio == $past(regWdata[4:2]) && cfg[0].sub == $past(regWdata[1:0]);
    endproperty
    a_ch0_field: assert property (p_ch0_field) else $error("ch0 fields misplaced");

    property p_usb_field;
        @(posedge clk) disable iff (rst)
            regWrite && regAddr == USB_FLASH_PRIO_ADDR |=> cfg[4].prio == $past(regWdata[12:10]);
    endproperty
    a_usb_field: assert property (p_usb_field) else $error("usb priority misplaced");

    property p_rsvd_read;
        @(posedge clk) disable iff (rst) regRead && regAddr == RSVD_PRIO_ADDR |=> regRdata == 32'h0;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved register not zero");

    property p_disabled;
        @(posedge clk) disable iff (rst)
            dmaIrqPending[0] && cfg[0].prio == PRIO_OFF |=> !(reqValid && reqVector == VEC_DMA0);
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled source won");

    property p_level_max;
        @(posedge clk) disable iff (rst)
            usbIrqPending && cfg[4].prio == PRIO_MAX |=> reqValid && reqLevel == PRIO_MAX;
    endproperty
    a_level_max: assert property (p_level_max) else $error("top level lost");

    property p_sub_tie;
        @(posedge clk) disable iff (rst)
            dmaIrqPending[1:0] == 2'b11 && cfg[0] == cfg[1] && cfg[0].prio != PRIO_OFF &&
            usbIrqPending == 1'b0 && flashIrqPending == 1'b0 && dmaIrqPending[3:2] == 2'b00
            |=> reqVector == VEC_DMA0;
    endproperty
    a_sub_tie: assert property (p_sub_tie) else $error("tie order wrong");

    property p_ch3_field;
        @(posedge clk) disable iff (rst)
            regWrite && regAddr == DMA_PRIO_ADDR |=>
            cfg[3].prio == $past(regWdata[28:26]) && cfg[3].sub == $past(regWdata[25:24]);
    endproperty
    a_ch3_field: assert property (p_ch3_field) else $error("ch3 fields misplaced");

    property p_flash_field;
        @(posedge clk) disable iff (rst)
            regWrite && regAddr == USB_FLASH_PRIO_ADDR |=>
            cfg[5].prio == $past(regWdata[4:2]) && cfg[5].sub == $past(regWdata[1:0]);
    endproperty
    a_flash_field: assert property (p_flash_field) else $error("flash fields misplaced");

    property p_rdata_idle;
        @(posedge clk) disable iff (rst) !regRead |=> regRdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");

    property p_dma_rsvd_bits;
        @(posedge clk) disable iff (rst)
            regRead && regAddr == DMA_PRIO_ADDR |=> (regRdata & ~DMA_PRIO_WMASK) == 32'h0;
    endproperty
    a_dma_rsvd_bits: assert property (p_dma_rsvd_bits) else $error("channel reserved bits set");

    property p_usb_rsvd_bits;
        @(posedge clk) disable iff (rst)
            regRead && regAddr == USB_FLASH_PRIO_ADDR |=> (regRdata & ~USB_FLASH_WMASK) == 32'h0;
    endproperty
    a_usb_rsvd_bits: assert property (p_usb_rsvd_bits) else $error("usb reserved bits set");

    property p_sub_wins;
        @(posedge clk) disable iff (rst)
            dmaIrqPending == 4'h3 && !usbIrqPending && !flashIrqPending && cfg[0].prio != PRIO_OFF &&
            cfg[1].prio == cfg[0].prio && cfg[1].sub > cfg[0].sub
            |=> reqVector == VEC_DMA0 + 6'h01;
    endproperty
    a_sub_wins: assert property (p_sub_wins) else $error("higher subpriority lost");

    property p_idle_req;
        @(posedge clk) disable iff (rst)
            dmaIrqPending == 4'h0 && !usbIrqPending && !flashIrqPending |=>
            !reqValid && reqVector == 6'h00 && reqLevel == PRIO_OFF;
    endproperty
    a_idle_req: assert property (p_idle_req) else $error("request without pending source");

    c_top: cover property (@(posedge clk) disable iff (rst) reqValid && reqLevel == PRIO_MAX);
    c_usb: cover property (@(posedge clk) disable iff (rst) reqValid && reqVector == VEC_USB);
    c_flash: cover property (@(posedge clk) disable iff (rst) reqValid && reqVector == VEC_FLASH);
    c_sub: cover property (@(posedge clk) disable iff (rst) cfg[3].sub == SUB_MAX && reqValid);

endmodule

//--- tb/core_model.sv
module core_model
    import irq_prio_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic reqValid,
    input wire logic [5:0] reqVector,
    input wire logic [2:0] reqLevel,
    output logic [5:0] servedVector
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] curLevel_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            curLevel_q <= 3'h0;
            servedVector <= 6'h00;
        end else if (reqValid && reqLevel > curLevel_q) begin
            curLevel_q <= reqLevel;
            servedVector <= reqVector;
        end
    end
endmodule

//--- tb/tb.sv
module tb;
    import irq_prio_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [31:0] regRdata;
    logic [3:0] dmaIrqPending = 4'h0;
    logic usbIrqPending = 1'b0;
    logic flashIrqPending = 1'b0;
    logic reqValid;
    logic [5:0] reqVector;
    logic [5:0] servedVector;
    logic [2:0] reqLevel;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #25 clk = ~clk;
    irq_priority_config_bank i_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .dmaIrqPending(dmaIrqPending),
        .usbIrqPending(usbIrqPending), .flashIrqPending(flashIrqPending), .reqValid(reqValid),
        .reqVector(reqVector), .reqLevel(reqLevel));
    core_model i_core (.clk(clk), .rst(rst), .reqValid(reqValid), .reqVector(reqVector),
        .reqLevel(reqLevel), .servedVector(servedVector));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic end_of_test();
        $display("Compares %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        chk(regRdata, exp, "read");
    endtask
    task automatic arb(input logic [5:0] pend, input logic v, input logic [5:0] vec, input logic [2:0] lvl);
        @(posedge clk);
        {usbIrqPending, flashIrqPending, dmaIrqPending} <= pend;
        repeat (2) @(posedge clk);
        #1;
        chk({22'h0, reqValid, reqVector, reqLevel}, {22'h0, v, vec, lvl}, "pick");
    endtask
    // ****************************************
    // Tests
    // ****************************************
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(DMA_PRIO_ADDR, 32'h0);
        rd(USB_FLASH_PRIO_ADDR, 32'h0);
        arb(6'h3f, 1'b0, 6'h00, 3'h0);
        $display("test reset done");
        wr(DMA_PRIO_ADDR, 32'hffff_ffff);
        rd(DMA_PRIO_ADDR, 32'h1f1f_1f1f);
        wr(RSVD_PRIO_ADDR, 32'hffff_ffff);
        rd(RSVD_PRIO_ADDR, 32'h0);
        wr(USB_FLASH_PRIO_ADDR, 32'hffff_ffff);
        rd(USB_FLASH_PRIO_ADDR, 32'h0000_1f1f);
        rd(8'h0c, 32'h0);
        arb(6'h3f, 1'b1, 6'h24, 3'h7);
        chk({26'h0, servedVector}, 32'h24, "core");
        $display("test fields done");
        wr(USB_FLASH_PRIO_ADDR, 32'h0);
        wr(DMA_PRIO_ADDR, 32'h0000_0d0c);
        arb(6'h02, 1'b1, 6'h25, 3'h3);
        arb(6'h03, 1'b1, 6'h25, 3'h3);
        arb(6'h01, 1'b1, 6'h24, 3'h3);
        wr(DMA_PRIO_ADDR, 32'h0000_0c0f);
        arb(6'h03, 1'b1, 6'h24, 3'h3);
        wr(DMA_PRIO_ADDR, 32'h0000_000c);
        arb(6'h02, 1'b0, 6'h00, 3'h0);
        wr(DMA_PRIO_ADDR, 32'h001c_000c);
        arb(6'h05, 1'b1, 6'h26, 3'h7);
        wr(USB_FLASH_PRIO_ADDR, 32'h0000_1c1c);
        arb(6'h35, 1'b1, 6'h26, 3'h7);
        arb(6'h30, 1'b1, 6'h2c, 3'h7);
        wr(USB_FLASH_PRIO_ADDR, 32'h0000_1d1c);
        arb(6'h30, 1'b1, 6'h2d, 3'h7);
        wr(USB_FLASH_PRIO_ADDR, 32'h0000_1c1d);
        arb(6'h14, 1'b1, 6'h2c, 3'h7);
        wr(DMA_PRIO_ADDR, 32'h1e1c_0000);
        arb(6'h0c, 1'b1, 6'h27, 3'h7);
        $display("test arbitration done");
        for (int l = 1; l < 8; l++) begin
            wr(DMA_PRIO_ADDR, {3'h0, l[2:0], 26'h0});
            arb(6'h08, 1'b1, 6'h27, l[2:0]);
        end
        $display("test levels done");
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd(DMA_PRIO_ADDR, 32'h0);
        arb(6'h3f, 1'b0, 6'h00, 3'h0);
        $display("test second reset done");
        end_of_test();
    end
endmodule
